// ===== core/acf_converter_ctrl.sv
// control, timing and result registers around a 10-bit sar converter core
// How it works
// - Each finished conversion loads new code into the high and low result bytes.
// - Justify-select 0 gives right-justified, 1 gives left-justified results.
// - Single-ended codes are 10-bit unsigned; all unused result bits read zero.
// - Differential right-justified results sign-extend into the high byte's upper bits.
// - Differential left-justified results clear the unused low bits of the low byte.
// - Normal tracking mode tracks the input while enabled and awake, except during a conversion.
// - Low-power tracking with a software start inserts three sar clock periods of tracking before converting.
// - Low-power with pin trigger: track while pin low, convert on rising edge.
// - Tracking stops completely while the chip is in standby or sleep.
// - Sar clock is system clock divided by divider field plus one.
// - Justify-select, bit 2, only acts when eight-bit mode is off.
`timescale 1ns/10ps
module acf_converter_ctrl
	import acf_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// special function register port
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	// chip power state
	input wire logic i_standby_sleep,
	// external start pin
	input wire logic i_external_convert_start_pin,
	// analogue converter core
	output logic o_track,
	output logic o_sar_clk_en,
	output logic o_conv_start,
	input wire logic i_conv_done,
	input wire logic [ACF_CODE_W-1:0] i_conv_code,
	// status
	output logic o_busy,
	output logic o_conv_complete
);
	import acf_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TRACK,
		ST_CONVERT
	} acf_state_t;

	acf_state_t state_q;
	acf_sfr_req_t req;
	acf_fmt_t fmt;
	logic [ACF_CFG_DIV_W-1:0] sar_clock_divider_q;
	logic left_justify_select_q;
	logic enable_q;
	logic low_power_track_select_q;
	logic pin_source_q;
	logic done_flag_q;
	logic eight_bit_mode_enable_q;
	logic differential_q;
	logic [7:0] result_high_byte_q;
	logic [7:0] result_low_byte_q;
	logic [1:0] track_cnt_q;
	logic pin_q;
	logic pin_rise;
	logic wr_cfg;
	logic wr_ctrl;
	logic wr_mode;
	logic sw_start;
	logic start_evt;
	logic sar_tick;
	logic div_run;
	logic conv_end;
	logic [15:0] fmt_word;
	logic track_d;
	logic begin_track;
	logic begin_conv;
	logic track_last;

	assign req = '{addr: i_sfr_addr, wr: i_sfr_wr, rd: i_sfr_rd, wdata: i_sfr_wdata};

	// write decode
	assign wr_cfg = req.wr && (req.addr == ACF_ADDR_CFG);
	assign wr_ctrl = req.wr && (req.addr == ACF_ADDR_CTRL);
	assign wr_mode = req.wr && (req.addr == ACF_ADDR_MODE);

	// configuration register; reserved low bits are not stored
	// a divider write lands at the divider's next reload
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			sar_clock_divider_q <= ACF_CFG_RESET[ACF_CFG_DIV_LSB +: ACF_CFG_DIV_W];
			left_justify_select_q <= ACF_CFG_RESET[ACF_CFG_LJST_BIT];
		end else if (wr_cfg) begin
			sar_clock_divider_q <= req.wdata[ACF_CFG_DIV_LSB +: ACF_CFG_DIV_W];
			left_justify_select_q <= req.wdata[ACF_CFG_LJST_BIT];
		end
	end

	// control register bits held by software
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			enable_q <= ACF_CTRL_RESET[ACF_CTRL_ENABLE_BIT];
			low_power_track_select_q <= ACF_CTRL_RESET[ACF_CTRL_LPTRACK_BIT];
			pin_source_q <= ACF_CTRL_RESET[ACF_CTRL_PINSRC_BIT];
		end else if (wr_ctrl) begin
			enable_q <= req.wdata[ACF_CTRL_ENABLE_BIT];
			low_power_track_select_q <= req.wdata[ACF_CTRL_LPTRACK_BIT];
			pin_source_q <= req.wdata[ACF_CTRL_PINSRC_BIT];
		end
	end

	// mode register
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			eight_bit_mode_enable_q <= ACF_MODE_RESET[ACF_MODE_8BIT_BIT];
			differential_q <= ACF_MODE_RESET[ACF_MODE_DIFF_BIT];
		end else if (wr_mode) begin
			eight_bit_mode_enable_q <= req.wdata[ACF_MODE_8BIT_BIT];
			differential_q <= req.wdata[ACF_MODE_DIFF_BIT];
		end
	end

	// start events
	// pin history resets low to match the pin's idle level
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= i_external_convert_start_pin;
		end
	end

	assign pin_rise = i_external_convert_start_pin && !pin_q;
	// starts are judged on the stored control bits: a write that sets enable
	// or low-power tracking together with start acts on the old settings
	assign sw_start = wr_ctrl && req.wdata[ACF_CTRL_START_BIT] && !pin_source_q;
	assign start_evt = enable_q && (pin_source_q ? pin_rise : sw_start);

	// low-power software starts track first; every other start converts at once
	assign begin_track = start_evt && low_power_track_select_q && !pin_source_q;
	assign begin_conv = start_evt && !(low_power_track_select_q && !pin_source_q);
	assign track_last = (state_q == ST_TRACK) && sar_tick
		&& (track_cnt_q == ACF_TRACK_SAR_CLKS - 2'd1);

	// sar clock divider runs only while a conversion sequence is active
	// idle cycles reload the count, so each sequence starts a full period
	assign div_run = (state_q != ST_IDLE);

	acf_sar_clk_div #(
		.DIV_W(ACF_CFG_DIV_W)
	) u_div (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_run(div_run),
		.i_div(sar_clock_divider_q),
		.o_tick(sar_tick)
	);

	assign conv_end = (state_q == ST_CONVERT) && i_conv_done;

	// sequencing; a start while busy is ignored
	// clearing enable aborts a running sequence
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			state_q <= ST_IDLE;
		end else if (!enable_q) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (begin_track) begin
						state_q <= ST_TRACK;
					end else if (begin_conv) begin
						state_q <= ST_CONVERT;
					end
				end
				ST_TRACK: begin
					if (track_last) begin
						state_q <= ST_CONVERT;
					end
				end
				ST_CONVERT: begin
					// a done pulse in any other state is ignored
					if (i_conv_done) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// counts sar clock periods of the low-power tracking interval
	always_ff @(posedge i_core_clk) begin
		if (i_srst || state_q != ST_TRACK) begin
			track_cnt_q <= 2'd0;
		end else if (sar_tick) begin
			track_cnt_q <= track_cnt_q + 2'd1;
		end
	end

	// one-cycle start pulse to the core as conversion begins
	always_ff @(posedge i_core_clk) begin
		if (i_srst || !enable_q) begin
			o_conv_start <= 1'b0;
		end else begin
			o_conv_start <= ((state_q == ST_IDLE) && begin_conv) || track_last;
		end
	end

	// track-and-hold control
	always_comb begin
		if (i_standby_sleep || !enable_q) begin
			track_d = 1'b0;
		end else if (!low_power_track_select_q) begin
			track_d = (state_q != ST_CONVERT);
		end else if (pin_source_q) begin
			track_d = (state_q == ST_IDLE) && !i_external_convert_start_pin;
		end else begin
			track_d = (state_q == ST_TRACK);
		end
	end

	// registered: tracking follows its cause one cycle later
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_track <= 1'b0;
		end else begin
			o_track <= track_d;
		end
	end

	assign o_sar_clk_en = (state_q == ST_CONVERT) && sar_tick;

	// result formatting
	assign fmt = '{differential: differential_q,
		left_justify_select: left_justify_select_q,
		eight_bit_mode_enable: eight_bit_mode_enable_q};

	acf_result_fmt u_fmt (
		.i_code(i_conv_code),
		.i_fmt(fmt),
		.o_word(fmt_word)
	);

	// result bytes load at the end of every conversion
	// eight-bit mode ignores justify select inside the formatter
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			result_high_byte_q <= 8'h00;
			result_low_byte_q <= 8'h00;
		end else if (conv_end) begin
			result_high_byte_q <= fmt_word[15:8];
			result_low_byte_q <= fmt_word[7:0];
		end
	end

	// completion flag; a new completion beats a software clear
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			done_flag_q <= 1'b0;
		end else if (conv_end) begin
			done_flag_q <= 1'b1;
		end else if (wr_ctrl && !req.wdata[ACF_CTRL_DONE_BIT]) begin
			done_flag_q <= 1'b0;
		end
	end

	assign o_busy = (state_q != ST_IDLE);
	assign o_conv_complete = done_flag_q;

	// read data, one cycle after the read strobe
	// reserved bits and the start bit always read as zero
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_sfr_rdata <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				ACF_ADDR_CFG: begin
					o_sfr_rdata <= {sar_clock_divider_q, left_justify_select_q, 2'b00};
				end
				ACF_ADDR_CTRL: begin
					o_sfr_rdata <= {enable_q, low_power_track_select_q, done_flag_q,
						o_busy, 3'b000, pin_source_q};
				end
				ACF_ADDR_MODE: begin
					o_sfr_rdata <= {6'h00, differential_q, eight_bit_mode_enable_q};
				end
				ACF_ADDR_RES_HIGH: begin
					o_sfr_rdata <= result_high_byte_q;
				end
				ACF_ADDR_RES_LOW: begin
					o_sfr_rdata <= result_low_byte_q;
				end
				default: begin
					o_sfr_rdata <= 8'h00;
				end
			endcase
		end
	end
endmodule // acf_converter_ctrl

// ===== core/acf_pkg.sv
// shared constants and types for the converter control and formatting block
package acf_pkg;

	// register addresses on the special function register port
	localparam logic [7:0] ACF_ADDR_CFG = 8'hbc;
	localparam logic [7:0] ACF_ADDR_RES_LOW = 8'hbd;
	localparam logic [7:0] ACF_ADDR_RES_HIGH = 8'hbe;
	localparam logic [7:0] ACF_ADDR_MODE = 8'hbf;
	localparam logic [7:0] ACF_ADDR_CTRL = 8'he8;

	// converter_configuration fields
	localparam int ACF_CFG_DIV_LSB = 3;
	localparam int ACF_CFG_DIV_W = 5;
	localparam int ACF_CFG_LJST_BIT = 2;
	localparam logic [7:0] ACF_CFG_RESET = 8'hf8;

	// converter_control_reg fields
	localparam int ACF_CTRL_ENABLE_BIT = 7;
	localparam int ACF_CTRL_LPTRACK_BIT = 6;
	localparam int ACF_CTRL_DONE_BIT = 5;
	localparam int ACF_CTRL_BUSY_BIT = 4;
	localparam int ACF_CTRL_START_BIT = 3;
	localparam int ACF_CTRL_PINSRC_BIT = 0;
	localparam logic [7:0] ACF_CTRL_RESET = 8'h00;

	// mode register fields
	localparam int ACF_MODE_8BIT_BIT = 0;
	localparam int ACF_MODE_DIFF_BIT = 1;
	localparam logic [7:0] ACF_MODE_RESET = 8'h00;

	// converter widths and low-power tracking length in sar clock periods
	localparam int ACF_CODE_W = 10;
	localparam logic [1:0] ACF_TRACK_SAR_CLKS = 2'd3;

	typedef struct packed {
		logic differential;
		logic left_justify_select;
		logic eight_bit_mode_enable;
	} acf_fmt_t;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} acf_sfr_req_t;

endpackage

// ===== core/acf_sar_clk_div.sv
// divides the system clock into one-cycle sar clock enable pulses
`timescale 1ns/10ps
module acf_sar_clk_div #(
	parameter int DIV_W = 5
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// control
	input wire logic i_run,
	input wire logic [DIV_W-1:0] i_div,
	// enable pulse, one per sar clock period
	output logic o_tick
);
	logic [DIV_W-1:0] cnt_q;

	// period is i_div + 1 system clocks; first pulse after one full period
	always_ff @(posedge i_core_clk) begin
		if (i_srst || !i_run) begin
			cnt_q <= i_div;
		end else if (cnt_q == '0) begin
			cnt_q <= i_div;
		end else begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign o_tick = i_run && (cnt_q == '0);
endmodule // acf_sar_clk_div

// ===== core/acf_result_fmt.sv
// arranges a raw conversion code into the two result bytes
`timescale 1ns/10ps
module acf_result_fmt
	import acf_pkg::*;
(
	// raw code and format selection
	input wire logic [ACF_CODE_W-1:0] i_code,
	input wire acf_pkg::acf_fmt_t i_fmt,
	// formatted high and low bytes
	output logic [15:0] o_word
);
	always_comb begin
		if (i_fmt.eight_bit_mode_enable) begin
			// eight-bit mode: top bits of the code in the low byte
			o_word = {8'h00, i_code[9:2]};
		end else if (i_fmt.left_justify_select) begin
			o_word = {i_code, 6'h00};
		end else if (i_fmt.differential) begin
			o_word = {{6{i_code[9]}}, i_code};
		end else begin
			o_word = {6'h00, i_code};
		end
	end
endmodule // acf_result_fmt

// ===== tb/acf_converter_ctrl_assertions.sv
// assertion checker for the converter control block
`timescale 1ns/10ps
module acf_converter_ctrl_chk
	import acf_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic i_standby_sleep,
	input wire logic o_track,
	input wire logic o_sar_clk_en,
	input wire logic o_conv_start,
	input wire logic i_conv_done,
	input wire logic o_busy,
	input wire logic o_conv_complete
);
	logic [4:0] div_q;
	logic [4:0] gap_q;
	logic seen_q;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	// divider shadow and gap since the last sar tick
	always_ff @(posedge i_core_clk) begin
		if (i_srst) div_q <= 5'h1f;
		else if (i_sfr_wr && i_sfr_addr == ACF_ADDR_CFG) div_q <= i_sfr_wdata[7:3];
	end
	always_ff @(posedge i_core_clk) begin
		if (i_srst || o_sar_clk_en) gap_q <= 5'h00;
		else gap_q <= gap_q + 5'h01;
	end
	always_ff @(posedge i_core_clk) begin
		if (i_srst || o_conv_start) seen_q <= 1'b0;
		else if (o_sar_clk_en) seen_q <= 1'b1;
	end
	AST_LOAD_ON_DONE: assert property (o_busy && i_conv_done |=> o_conv_complete && !o_busy)
		else $error("no load after done");
	AST_FLAG_WITH_LOAD: assert property ($rose(o_conv_complete) |-> $fell(o_busy))
		else $error("flag apart from load");
	AST_HOLD_IN_CONV: assert property (o_conv_start |=> (!o_track)[*2])
		else $error("tracking while converting");
	AST_STANDBY_NO_TRACK: assert property (i_standby_sleep |=> !o_track)
		else $error("tracking in standby");
	AST_TICK_SPACING: assert property (o_sar_clk_en && seen_q |-> gap_q == div_q)
		else $error("sar tick spacing");
	AST_TICK_IN_BUSY: assert property (o_sar_clk_en |-> o_busy)
		else $error("sar tick while idle");
	AST_CFG_READBACK: assert property (i_sfr_rd && i_sfr_addr == ACF_ADDR_CFG |=>
		o_sfr_rdata[7:3] == div_q && o_sfr_rdata[1:0] == 2'b00)
		else $error("configuration readback");
	AST_START_IN_BUSY: assert property (o_conv_start |-> o_busy)
		else $error("start outside busy");
endmodule // acf_converter_ctrl_chk
bind acf_converter_ctrl acf_converter_ctrl_chk u_chk (.*);

// ===== tb/acf_core_model.sv
// behavioural model of the analogue converter core
`timescale 1ns/10ps
module acf_core_model
	import acf_pkg::*;
#(
	parameter int NTICKS = 4
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_conv_start,
	input wire logic i_sar_clk_en,
	input wire logic [ACF_CODE_W-1:0] i_code,
	output logic o_conv_done,
	output logic [ACF_CODE_W-1:0] o_conv_code
);
	logic active_q;
	int cnt_q;
	wire logic fire = active_q && i_sar_clk_en && cnt_q == NTICKS - 1;
	always_ff @(posedge i_core_clk) begin
		if (i_srst || fire) active_q <= 1'b0;
		else if (i_conv_start) active_q <= 1'b1;
	end
	always_ff @(posedge i_core_clk) begin
		if (i_srst || i_conv_start) cnt_q <= 0;
		else if (active_q && i_sar_clk_en) cnt_q <= cnt_q + 1;
	end
	// code valid only with done, scrambled otherwise
	always_ff @(posedge i_core_clk) begin
		o_conv_done <= fire && !i_srst;
		if (i_srst) o_conv_code <= '0;
		else o_conv_code <= fire ? i_code : ~o_conv_code;
	end
endmodule // acf_core_model

// ===== tb/acf_converter_ctrl_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
module acf_converter_ctrl_tb;
	import acf_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic standby = 1'b0;
	logic pin = 1'b0;
	logic [9:0] code = 10'h000;
	logic [7:0] rdata;
	logic track, sar_en, start, done, busy, cplt;
	logic [9:0] core_code;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	int n;
	logic [31:0] rnd = 32'h25683bad;
	logic [4:0] div;
	logic [7:0] hi;
	logic [7:0] lo;
	logic [9:0] corner [4] = '{10'h3ff, 10'h200, 10'h1ff, 10'h000};
	acf_converter_ctrl uut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_sfr_addr(addr),
		.i_sfr_wr(wr_en), .i_sfr_rd(rd_en), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
		.i_standby_sleep(standby), .i_external_convert_start_pin(pin), .o_track(track),
		.o_sar_clk_en(sar_en), .o_conv_start(start), .i_conv_done(done),
		.i_conv_code(core_code), .o_busy(busy), .o_conv_complete(cplt));
	acf_core_model core (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_conv_start(start),
		.i_sar_clk_en(sar_en), .i_code(code), .o_conv_done(done), .o_conv_code(core_code));
	initial forever #4 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] fmt(input logic [9:0] c, input logic d, lj, eb);
		if (eb) return {8'h00, c[9:2]};
		if (lj) return {c, 6'h00};
		return {{6{d & c[9]}}, c};
	endfunction
	task automatic final_report();
		if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic step();
		@(posedge i_core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, d);
		step();
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		step();
		wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		step();
		addr = a;
		rd_en = 1'b1;
		step();
		rd_en = 1'b0;
		d = rdata;
	endtask
	// start, time the start pulse, wait for the result
	task automatic go(input logic [7:0] ctrl, output int k);
		int m;
		if (ctrl[ACF_CTRL_PINSRC_BIT]) begin
			step();
			pin = 1'b1;
			step();
		end else wr(ACF_ADDR_CTRL, ctrl);
		for (k = 1; start !== 1'b1 && k < 300; k++) step();
		check({15'h0000, busy}, 16'h0001);
		for (m = 0; cplt !== 1'b1 && m < 600; m++) step();
		check(16'(m < 600), 16'h0001);
		check({15'h0000, busy}, 16'h0000);
	endtask
	initial begin
		repeat (16) step();
		i_srst = 1'b0;
		rd(ACF_ADDR_CFG, lo);
		check({8'h00, lo}, 16'h00f8);
		rd(8'hc0, lo);
		check({8'h00, lo}, 16'h0000);
		wr(ACF_ADDR_CTRL, 8'h80);
		for (int i = 0; i < 40; i++) begin
			rnd = lfsr(rnd);
			div = {3'b000, rnd[11:10]} | 5'h01;
			code = (i < 32) ? corner[i[4:3]] : rnd[9:0];
			wr(ACF_ADDR_MODE, {6'h00, i[1], i[0]});
			wr(ACF_ADDR_CFG, {div, i[2], 2'b00});
			go(8'h88, n);
			check(16'(n), 16'h0001);
			rd(ACF_ADDR_RES_HIGH, hi);
			rd(ACF_ADDR_RES_LOW, lo);
			check({hi, lo}, fmt(code, i[1], i[2], i[0]));
			check({15'h0000, track}, 16'h0001);
			wr(ACF_ADDR_CTRL, 8'h80);
			check({15'h0000, cplt}, 16'h0000);
		end
		wr(ACF_ADDR_CFG, 8'h18);
		wr(ACF_ADDR_CTRL, 8'hc0);
		go(8'hc8, n);
		check(16'(n), 16'd13);
		wr(ACF_ADDR_CTRL, 8'hc1);
		repeat (2) step();
		check({15'h0000, track}, 16'h0001);
		go(8'hc1, n);
		check(16'(n), 16'h0001);
		check({15'h0000, track}, 16'h0000);
		pin = 1'b0;
		standby = 1'b1;
		repeat (2) step();
		check({15'h0000, track}, 16'h0000);
		standby = 1'b0;
		repeat (2) step();
		check({15'h0000, track}, 16'h0001);
		wr(ACF_ADDR_CTRL, 8'h81);
		go(8'h81, n);
		check(16'(n), 16'h0001);
		step();
		check({15'h0000, track}, 16'h0001);
		final_report();
	end
endmodule // acf_converter_ctrl_tb
